// [verilog/dpg_module.sv]
module dpg_module
	import dpg_pkg::*;
#(
	parameter int PORT_W = DPG_PORT_W
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] rdata,
	input wire logic [PORT_W-1:0] first_pin_in,
	input wire logic [PORT_W-1:0] second_pin_in,
	output logic [PORT_W-1:0] first_pin_out,
	output logic [PORT_W-1:0] first_pin_oe,
	output logic [PORT_W-1:0] second_pin_out,
	output logic [PORT_W-1:0] second_pin_oe
);

	logic [PORT_W-1:0] first_port_value, second_port_value;
	logic [PORT_W-1:0] first_port_direction, second_port_direction;
	logic [PORT_W-1:0] first_sync1, first_sync2, second_sync1, second_sync2;
	logic [PORT_W-1:0] next_first_value, next_second_value, next_first_dir, next_second_dir;
	logic [PORT_W-1:0] first_bits, second_bits;
	logic wr_en, rd_en;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;

	// Input readback mixes held value with synchronised pin level per direction bit.
	assign first_bits = (first_port_direction & first_port_value) | (~first_port_direction & first_sync2);
	assign second_bits = (second_port_direction & second_port_value) | (~second_port_direction & second_sync2);

	always_comb begin
		next_first_value = first_port_value;
		next_second_value = second_port_value;
		next_first_dir = first_port_direction;
		next_second_dir = second_port_direction;
		rdata = DPG_RDATA_RST;
		// Upper bits are dropped on write; reserved offsets absorb writes.
		if (wr_en) begin
			unique case (paddr)
				DPG_OFS_FIRST_VALUE: next_first_value = pwdata[PORT_W-1:0];
				DPG_OFS_SECOND_VALUE: next_second_value = pwdata[PORT_W-1:0];
				DPG_OFS_FIRST_DIR: next_first_dir = pwdata[PORT_W-1:0];
				DPG_OFS_SECOND_DIR: next_second_dir = pwdata[PORT_W-1:0];
				default: ;
			endcase
		end
		// The read word is combinational; the top registers it at the setup edge, so the
		// bus sees one flop and no second copy of the word is held per module.
		if (rd_en) begin
			unique case (paddr)
				DPG_OFS_FIRST_VALUE: rdata = {{(32-PORT_W){1'b0}}, first_bits};
				DPG_OFS_SECOND_VALUE: rdata = {{(32-PORT_W){1'b0}}, second_bits};
				DPG_OFS_FIRST_DIR: rdata = {{(32-PORT_W){1'b0}}, first_port_direction};
				DPG_OFS_SECOND_DIR: rdata = {{(32-PORT_W){1'b0}}, second_port_direction};
				default: rdata = DPG_RDATA_RST;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			first_port_value <= DPG_VALUE_RST;
			second_port_value <= DPG_VALUE_RST;
			first_port_direction <= DPG_DIR_RST;
			second_port_direction <= DPG_DIR_RST;
			first_sync1 <= '0;
			first_sync2 <= '0;
			second_sync1 <= '0;
			second_sync2 <= '0;
			first_pin_out <= '0;
			first_pin_oe <= '0;
			second_pin_out <= '0;
			second_pin_oe <= '0;
		end else if (clk_en) begin
			first_port_value <= next_first_value;
			second_port_value <= next_second_value;
			first_port_direction <= next_first_dir;
			second_port_direction <= next_second_dir;
			first_sync1 <= first_pin_in;
			first_sync2 <= first_sync1;
			second_sync1 <= second_pin_in;
			second_sync2 <= second_sync1;
			first_pin_out <= next_first_value & next_first_dir;
			first_pin_oe <= next_first_dir;
			second_pin_out <= next_second_value & next_second_dir;
			second_pin_oe <= next_second_dir;
		end
	end

endmodule

// [shared/dpg_pkg.sv]
package dpg_pkg;

	localparam int DPG_PORT_W = 8;
	localparam int DPG_NUM_MODULES = 4;
	localparam int DPG_APB_AW = 32;
	localparam int DPG_APB_DW = 32;

	// Register offsets within one module.
	localparam logic [11:0] DPG_OFS_FIRST_VALUE = 12'h000;
	localparam logic [11:0] DPG_OFS_SECOND_VALUE = 12'h004;
	localparam logic [11:0] DPG_OFS_FIRST_DIR = 12'h008;
	localparam logic [11:0] DPG_OFS_SECOND_DIR = 12'h00C;
	localparam logic [11:0] DPG_OFS_RSVD_LO = 12'h010;
	localparam logic [11:0] DPG_OFS_RSVD_HI = 12'h0FF;

	// Module bases, descending in 4 KB steps.
	localparam logic [31:0] DPG_BASE_TOP = 32'hFFFDF000;
	localparam logic [31:0] DPG_BASE_STEP = 32'h00001000;
	localparam logic [31:0] DPG_BASE_MASK = 32'hFFFFF000;

	// Field layout and reset values.
	localparam int DPG_FIELD_LSB = 0;
	localparam logic [7:0] DPG_VALUE_RST = 8'h00;
	localparam logic [7:0] DPG_DIR_RST = 8'h00;
	localparam logic [31:0] DPG_RDATA_RST = 32'h00000000;

	// APB access phases.
	typedef enum logic [1:0] {
		DPG_IDLE = 2'b01,
		DPG_ACCESS = 2'b10
	} dpg_phase_e;

endpackage

// [verilog/dpg_top.sv]
// Notes on behaviour
// - Two 8-bit ports, each bit input or output.
// - Four modules give eight ports, 64 bits.
// - Direction follows last written direction value.
// - Software reads back direction registers; data reads show pin level on input bits.
// - Reset leaves every bit an input.
// - Data registers at offsets 0x000 and 0x004.
// - Direction registers at offsets 0x008 and 0x00C.
// - Each module is an APB slave.
// - Bases descend in 4 KB steps from top.
// - Pins pass external multiplexers with alternate functions.
// - Data read: output bits held, input bits pin.
// - Direction one drives pin, zero makes input.
// - Data reaches pins only on output bits.
// - Reset clears data and direction registers.
module dpg_top
	import dpg_pkg::*;
#(
	parameter int NUM_MODULES = DPG_NUM_MODULES,
	parameter int PORT_W = DPG_PORT_W
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2*NUM_MODULES*PORT_W-1:0] pin_in,
	output logic [2*NUM_MODULES*PORT_W-1:0] pin_out,
	output logic [2*NUM_MODULES*PORT_W-1:0] pin_oe
);

	// Port k of module m sits at bits [(2m+k)*PORT_W +: PORT_W]; external pin muxing selects
	// between these and alternate functions, so pin_oe is only the GPIO request.
	logic [NUM_MODULES-1:0] hit;
	logic [31:0] mod_rdata [NUM_MODULES];
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;

	// Read data is captured at the setup edge, so it stands through the access cycle and
	// until the next read setup. Unmapped reads return zero.
	always_comb begin
		next_prdata = prdata;
		next_pready = 1'b1;
		next_pslverr = 1'b0;
		if (psel && !penable && !pwrite) begin
			next_prdata = DPG_RDATA_RST;
			for (int m = 0; m < NUM_MODULES; m++) begin
				if (hit[m]) begin
					next_prdata = mod_rdata[m];
				end
			end
		end
	end

	// Zero-wait APB: ready and error are flops that keep their idle values, so every
	// access completes in its first access cycle without error.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			prdata <= DPG_RDATA_RST;
			pready <= 1'b1;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_MODULES; g++) begin : g_mod
			logic [31:0] base;
			assign base = DPG_BASE_TOP - DPG_BASE_STEP * 32'(g);
			assign hit[g] = (paddr & DPG_BASE_MASK) == base;
			dpg_module #(.PORT_W(PORT_W)) u_mod (
				.sys_clk(sys_clk),
				.sys_rst(sys_rst),
				.clk_en(clk_en),
				.psel(psel && hit[g]),
				.penable(penable),
				.pwrite(pwrite),
				.paddr(paddr[11:0]),
				.pwdata(pwdata),
				.rdata(mod_rdata[g]),
				.first_pin_in(pin_in[(2*g)*PORT_W +: PORT_W]),
				.second_pin_in(pin_in[(2*g+1)*PORT_W +: PORT_W]),
				.first_pin_out(pin_out[(2*g)*PORT_W +: PORT_W]),
				.first_pin_oe(pin_oe[(2*g)*PORT_W +: PORT_W]),
				.second_pin_out(pin_out[(2*g+1)*PORT_W +: PORT_W]),
				.second_pin_oe(pin_oe[(2*g+1)*PORT_W +: PORT_W])
			);
		end
	endgenerate

endmodule

// [test/dpg_assertions.sv]
module dpg_assertions
	import dpg_pkg::*;
#(
	parameter int NUM_MODULES = DPG_NUM_MODULES,
	parameter int PORT_W = DPG_PORT_W
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [2*NUM_MODULES*PORT_W-1:0] pin_in,
	input wire logic [2*NUM_MODULES*PORT_W-1:0] pin_out,
	input wire logic [2*NUM_MODULES*PORT_W-1:0] pin_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	wire logic wr = psel && penable && pwrite && clk_en;
	wire logic rd = psel && !penable && !pwrite && clk_en;
	a_ready_high: assert property (pready) else $error("ready low");
	a_no_error: assert property (!pslverr) else $error("error response");
	a_out_masked: assert property ((pin_out & ~pin_oe) == '0) else $error("input bit driven");
	a_reset_clear: assert property ($past(sys_rst) |-> pin_oe == '0 && pin_out == '0)
		else $error("pins not cleared");
	a_dir_write: assert property (wr && paddr == 32'hFFFDF008 |=> pin_oe[7:0] == $past(pwdata[7:0]))
		else $error("direction wrong");
	a_data_write: assert property (wr && paddr == 32'hFFFDF000 |=>
		pin_out[7:0] == ($past(pwdata[7:0]) & pin_oe[7:0])) else $error("data wrong");
	a_rsvd_write: assert property (wr && paddr[11:0] >= 12'h010 |=> $stable(pin_oe) && $stable(pin_out))
		else $error("reserved write took effect");
	a_rsvd_read: assert property (rd && paddr[11:0] >= 12'h010 |=> prdata == 32'h00000000)
		else $error("reserved read not zero");
	a_upper_zero: assert property (rd |=> prdata[31:8] == 24'h000000) else $error("upper bits set");
endmodule
bind dpg_top dpg_assertions #(.NUM_MODULES(NUM_MODULES), .PORT_W(PORT_W)) i_dpg_assertions(
	.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

// [test/dpg_pins_model.sv]
module dpg_pins_model
	import dpg_pkg::*;
#(
	parameter int W = 2*DPG_NUM_MODULES*DPG_PORT_W
) (
	input wire logic [W-1:0] pin_out,
	input wire logic [W-1:0] pin_oe,
	input wire logic [W-1:0] ext_level,
	output logic [W-1:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// A driven bit reads its own drive back; an undriven bit sees the board level.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// [test/tb_dpg_top.sv]
module tb_dpg_top
	import dpg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, sys_rst = 1, clk_en = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [31:0] paddr = '0, pwdata = '0, prdata, b, d;
	logic [63:0] pin_in, pin_out, pin_oe, ext = '0;
	int errors = 0, comparisons = 0;
	dpg_top i_dpg_top(.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
	dpg_pins_model i_dpg_pins_model(.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
	initial forever #12.5 sys_clk = ~sys_clk;
	task automatic report_and_stop();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] v, output logic [31:0] r);
		@(posedge sys_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= v;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		r = prdata;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h00000000, d);
		chk({32'h00000000, d}, {32'h00000000, e});
	endtask
	initial begin
		repeat (5000) @(posedge sys_clk);
		errors++;
		report_and_stop();
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			b = DPG_BASE_TOP - m * DPG_BASE_STEP;
			for (int o = 0; o < 16; o += 4) rd(b + o, 32'h00000000);
		end
		chk(pin_oe, 64'h0);
		ext <= {8{8'h96}};
		for (int m = 0; m < 4; m++) begin
			b = DPG_BASE_TOP - m * DPG_BASE_STEP;
			acc(1'b1, b + 32'h8, 32'h0F, d);
			acc(1'b1, b + 32'hC, 32'hF0, d);
			acc(1'b1, b, 32'hA5, d);
			acc(1'b1, b + 32'h4, 32'h3C, d);
			acc(1'b1, b + 32'h100, 32'hFF, d);
			acc(1'b1, b + 32'hFFC, 32'hFF, d);
			rd(b + 32'h8, 32'h0F);
			rd(b + 32'hC, 32'hF0);
			rd(b, 32'h95);
			rd(b + 32'h4, 32'h36);
			rd(b + 32'h10, 32'h00);
		end
		chk(pin_oe, {4{16'hF00F}});
		chk(pin_out, {4{16'h3005}});
		rd(32'hFFFD0000, 32'h00);
		acc(1'b1, DPG_BASE_TOP + 32'h8, 32'h00, d);
		ext <= {8{8'h69}};
		repeat (2) @(posedge sys_clk);
		rd(DPG_BASE_TOP, 32'h69);
		chk(pin_oe[7:0], 8'h00);
		report_and_stop();
	end
endmodule
